// ===== hw/fpx_pkg.sv
/*
 * fpx_pkg: shared constants for the fp exception result selector.
 * assumes single operands sit in the low 32 bits of a 64-bit word.
 */
package fpx_pkg;
    typedef enum logic [3:0] {
        single_add_op,
        double_add_op,
        single_subtract_op,
        double_subtract_op,
        single_multiply_op,
        double_multiply_op,
        single_divide_op,
        double_divide_op,
        single_to_double_multiply
    } fpx_op_t;

    // status bit positions: invalid, nan result, overflow, underflow, inexact, div by zero
    localparam int ST_N = 0;
    localparam int ST_R = 1;
    localparam int ST_V = 2;
    localparam int ST_U = 3;
    localparam int ST_X = 4;
    localparam int ST_D = 5;
    localparam int ST_W = 6;

    // control register fields
    localparam int CTL_FAST = 6;
    localparam int CTL_RM_LO = 7;
    localparam int CTL_W = 9;
    localparam logic [8:0] CTL_RESET = 9'h03f;

    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_TO_NEG = 2'h1;
    localparam logic [1:0] RM_TO_POS = 2'h2;

    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STICKY = 8'h04;
    localparam logic [7:0] OFS_TRAP = 8'h08;
    localparam logic [7:0] OFS_EVENT = 8'h0c;
    localparam logic [7:0] OFS_EVMASK = 8'h10;

    localparam logic [63:0] QNAN_D = 64'h7ffc000000000000;
    localparam logic [31:0] QNAN_S = 32'h7fe00000;
    localparam logic [63:0] INF_D = 64'h7ff0000000000000;
    localparam logic [31:0] INF_S = 32'h7f800000;
    localparam logic [63:0] MAX_D = 64'h7fefffffffffffff;
    localparam logic [31:0] MAX_S = 32'h7f7fffff;
endpackage

// ===== hw/fpx_classify.sv
/*
 * fpx_classify: sorts one operand into nan, infinity and zero classes.
 * assumes a single operand occupies bits 31:0 when i_double is low.
 */
`timescale 1ns/1ps
module fpx_classify (
    input wire logic [63:0] i_operand,
    input wire logic i_double,
    output logic o_sign,
    output logic o_zero,
    output logic o_inf,
    output logic o_qnan,
    output logic o_snan
);
    logic emax;
    logic ezero;
    logic fzero;
    logic quiet;

    always_comb begin
        o_sign = i_double ? i_operand[63] : i_operand[31];
        emax = i_double ? &i_operand[62:52] : &i_operand[30:23];
        ezero = i_double ? ~|i_operand[62:52] : ~|i_operand[30:23];
        fzero = i_double ? ~|i_operand[51:0] : ~|i_operand[22:0];
        quiet = i_double ? i_operand[51] : i_operand[22];
        o_zero = ezero & fzero;
        o_inf = emax & fzero;
        o_qnan = emax & ~fzero & quiet;
        o_snan = emax & ~fzero & ~quiet;
    end
endmodule

// ===== hw/fpx_event_irq.sv
/*
 * fpx_event_irq: sticky event bits cleared by a read, a mask, one irq level.
 * assumes i_read_clear pulses once per accepted read of the event register.
 */
`timescale 1ns/1ps
module fpx_event_irq #(
    parameter int W = 6
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_set,
    input wire logic i_read_clear,
    input wire logic i_mask_we,
    input wire logic [W-1:0] i_mask_wdata,
    output logic [W-1:0] o_status,
    output logic [W-1:0] o_mask,
    output logic o_irq
);
    logic [W-1:0] status_q, status_d;
    logic [W-1:0] mask_q, mask_d;

    always_comb begin
        // a new event in the clearing cycle survives
        status_d = (status_q & ~(i_read_clear ? status_q : '0)) | i_set;
        mask_d = i_mask_we ? i_mask_wdata : mask_q;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            status_q <= '0;
            mask_q <= '0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
        end
    end

    assign o_status = status_q;
    assign o_mask = mask_q;
    assign o_irq = |(status_q & mask_q);
endmodule

// ===== hw/fpx_exc_select.sv
/*
 * fpx_exc_select: picks result, status and write enable for fp add, subtract,
 * multiply and divide when operands or results are exceptional.
 * assumes the arithmetic core supplies the rounded result and the overflow,
 * tiny, inexact and sign flags of the intermediate result with the operands.
 */
`timescale 1ns/1ps
module fpx_exc_select (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_op_valid,
    input wire fpx_pkg::fpx_op_t i_op_code,
    input wire logic [63:0] i_first_source_operand,
    input wire logic [63:0] i_second_source_operand,
    input wire logic [63:0] i_rounded_result,
    input wire logic i_intermediate_sign,
    input wire logic i_intermediate_overflow,
    input wire logic i_intermediate_tiny,
    input wire logic i_intermediate_inexact,
    output logic o_res_valid,
    output logic [63:0] o_result,
    output logic o_result_write,
    output logic o_result_suppressed,
    output logic [5:0] o_exc_status,
    output logic o_trap,
    output logic o_irq
);
    import fpx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // operand classes
    logic dbl_in, dbl_out, is_add, is_sub, is_mul, is_div, is_widen_mul;
    logic sa, za, ia, qa, na, sb, zb, ib, qb, nb;
    logic [CTL_W-1:0] ctrl_q, ctrl_d;
    logic [5:0] masks;
    logic ovf_mask, unf_mask, inx_mask, fast_float_enable;
    logic [1:0] rounding_mode_field;

    always_comb begin
        dbl_in = (i_op_code == double_add_op) || (i_op_code == double_subtract_op) ||
                 (i_op_code == double_multiply_op) || (i_op_code == double_divide_op);
        is_widen_mul = (i_op_code == single_to_double_multiply);
        dbl_out = dbl_in | is_widen_mul;
        is_add = (i_op_code == single_add_op) || (i_op_code == double_add_op);
        is_sub = (i_op_code == single_subtract_op) || (i_op_code == double_subtract_op);
        is_mul = (i_op_code == single_multiply_op) || (i_op_code == double_multiply_op) || is_widen_mul;
        is_div = (i_op_code == single_divide_op) || (i_op_code == double_divide_op);
    end

    fpx_classify u_class_a (
        .i_operand(i_first_source_operand),
        .i_double(dbl_in),
        .o_sign(sa),
        .o_zero(za),
        .o_inf(ia),
        .o_qnan(qa),
        .o_snan(na)
    );

    fpx_classify u_class_b (
        .i_operand(i_second_source_operand),
        .i_double(dbl_in),
        .o_sign(sb),
        .o_zero(zb),
        .o_inf(ib),
        .o_qnan(qb),
        .o_snan(nb)
    );

    assign masks = ctrl_q[5:0];
    assign ovf_mask = ctrl_q[ST_V];
    assign unf_mask = ctrl_q[ST_U];
    assign inx_mask = ctrl_q[ST_X];
    assign fast_float_enable = ctrl_q[CTL_FAST];
    assign rounding_mode_field = ctrl_q[CTL_RM_LO+:2];

    function automatic logic [63:0] fp_val(input logic d, input logic s, input logic [63:0] md,
                                           input logic [31:0] ms);
        fp_val = d ? {s, md[62:0]} : {32'h0, s, ms[30:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // result and status selection
    logic [63:0] canonical_quiet_nan, res_d, res_q;
    logic [5:0] stat_d, stat_q;
    logic wr_d, wr_q, vld_q, trap_d, trap_q;
    logic sx, sbe, numeric, uf, big, any_snan, any_nan;

    always_comb begin
        canonical_quiet_nan = fp_val(dbl_out, 1'b0, QNAN_D, QNAN_S);
        sx = sa ^ sb;
        sbe = sb ^ is_sub;
        any_snan = na | nb;
        any_nan = any_snan | qa | qb;
        stat_d = '0;
        res_d = i_rounded_result;
        wr_d = 1'b1;
        numeric = 1'b0;
        // first matching branch is the highest ranked exception
        if (any_snan) begin
            res_d = canonical_quiet_nan;
            stat_d[ST_N] = 1'b1;
            stat_d[ST_R] = 1'b1;
        end else if (qa | qb) begin
            res_d = canonical_quiet_nan;
            stat_d[ST_R] = 1'b1;
        end else if (is_add | is_sub) begin
            if (ia & ib & (sa != sbe)) begin
                res_d = canonical_quiet_nan;
                stat_d[ST_N] = 1'b1;
                stat_d[ST_R] = 1'b1;
            end else if (ia) begin
                res_d = fp_val(dbl_out, sa, INF_D, INF_S);
            end else if (ib) begin
                res_d = fp_val(dbl_out, sbe, INF_D, INF_S);
            end else begin
                numeric = 1'b1;
            end
        end else if (is_mul) begin
            if ((ia & zb) | (za & ib)) begin
                res_d = canonical_quiet_nan;
                stat_d[ST_N] = 1'b1;
                stat_d[ST_R] = 1'b1;
            end else if (ia | ib) begin
                res_d = fp_val(dbl_out, sx, INF_D, INF_S);
            end else if (za | zb) begin
                res_d = fp_val(dbl_out, sx, 64'h0, 32'h0);
            end else begin
                numeric = ~is_widen_mul;
            end
        end else begin
            if ((za & zb) | (ia & ib)) begin
                res_d = canonical_quiet_nan;
                stat_d[ST_N] = 1'b1;
                stat_d[ST_R] = 1'b1;
            end else if (ia) begin
                res_d = fp_val(dbl_out, sx, INF_D, INF_S);
            end else if (zb) begin
                res_d = fp_val(dbl_out, sx, INF_D, INF_S);
                stat_d[ST_D] = 1'b1;
            end else if (za | ib) begin
                res_d = fp_val(dbl_out, sx, 64'h0, 32'h0);
            end else begin
                numeric = 1'b1;
            end
        end
        // underflow test depends on mask and fast-float
        uf = i_intermediate_tiny & (~unf_mask | fast_float_enable | i_intermediate_inexact) &
             ~((is_add | is_sub) & unf_mask & ~fast_float_enable);
        big = (rounding_mode_field == RM_NEAREST) ||
              (rounding_mode_field == (i_intermediate_sign ? RM_TO_NEG : RM_TO_POS));
        if (numeric) begin
            if (i_intermediate_overflow) begin
                stat_d[ST_V] = 1'b1;
                if (ovf_mask) begin
                    res_d = big ? fp_val(dbl_out, i_intermediate_sign, INF_D, INF_S) :
                                  fp_val(dbl_out, i_intermediate_sign, MAX_D, MAX_S);
                    stat_d[ST_X] = 1'b1;
                end else begin
                    wr_d = 1'b0;
                    stat_d[ST_X] = i_intermediate_inexact;
                end
            end else if (uf) begin
                stat_d[ST_U] = 1'b1;
                if (unf_mask & fast_float_enable) begin
                    res_d = fp_val(dbl_out, i_intermediate_sign, 64'h0, 32'h0);
                    stat_d[ST_X] = 1'b1;
                end else if (unf_mask) begin
                    stat_d[ST_X] = 1'b1;
                end else begin
                    wr_d = 1'b0;
                    stat_d[ST_X] = i_intermediate_inexact;
                end
            end else if (i_intermediate_inexact) begin
                stat_d[ST_X] = 1'b1;
                wr_d = inx_mask;
            end
        end
        trap_d = |(stat_d & ~masks);
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            vld_q <= 1'b0;
            res_q <= 64'h0;
            stat_q <= '0;
            wr_q <= 1'b0;
            trap_q <= 1'b0;
        end else begin
            vld_q <= i_op_valid;
            if (i_op_valid) begin
                // the result register only moves on a real write
                if (wr_d) begin
                    res_q <= res_d;
                end
                stat_q <= stat_d;
                wr_q <= wr_d;
                trap_q <= trap_d;
            end
        end
    end

    assign o_res_valid = vld_q;
    assign o_result = res_q;
    assign o_result_write = vld_q & wr_q;
    assign o_result_suppressed = vld_q & ~wr_q;
    assign o_exc_status = stat_q;
    assign o_trap = vld_q & trap_q;

    ////////////////////////////////////////////////////////////////////////////
    // registers over avalon-mm, one wait state per access
    logic ack_q, ack_d, acc;
    logic [31:0] rdata_q, rdata_d;
    logic [5:0] sticky_q, sticky_d, trap_st_q, trap_st_d, ev_status, ev_mask;
    logic sticky_we, ev_clear, ev_mask_we;

    assign acc = (i_avs_read | i_avs_write) & ack_q;
    assign sticky_we = acc & i_avs_write & (i_avs_address == OFS_STICKY) & i_avs_byteenable[0];
    assign ev_clear = acc & i_avs_read & (i_avs_address == OFS_EVENT);
    assign ev_mask_we = acc & i_avs_write & (i_avs_address == OFS_EVMASK) & i_avs_byteenable[0];

    always_comb begin
        ack_d = (i_avs_read | i_avs_write) & ~ack_q;
        ctrl_d = ctrl_q;
        if (acc & i_avs_write & (i_avs_address == OFS_CONTROL)) begin
            if (i_avs_byteenable[0]) begin
                ctrl_d[7:0] = i_avs_writedata[7:0];
            end
            if (i_avs_byteenable[1]) begin
                ctrl_d[8] = i_avs_writedata[8];
            end
        end
        // sticky bits follow the mask; hardware set beats a software write
        sticky_d = (sticky_we ? i_avs_writedata[5:0] : sticky_q) |
                   ({6{vld_q}} & stat_q & masks);
        trap_st_d = (vld_q & trap_q) ? stat_q : trap_st_q;
        unique case (i_avs_address)
            OFS_CONTROL: rdata_d = {23'h0, ctrl_q};
            OFS_STICKY: rdata_d = {26'h0, sticky_q};
            OFS_TRAP: rdata_d = {26'h0, trap_st_q};
            OFS_EVENT: rdata_d = {26'h0, ev_status};
            OFS_EVMASK: rdata_d = {26'h0, ev_mask};
            default: rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            ctrl_q <= CTL_RESET;
            sticky_q <= '0;
            trap_st_q <= '0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            sticky_q <= sticky_d;
            trap_st_q <= trap_st_d;
        end
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign o_avs_readdata = rdata_q;

    // a trap raises the event bits of every status bit of the trapping op, masked or not
    fpx_event_irq #(
        .W(ST_W)
    ) u_events (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_set({6{vld_q & trap_q}} & stat_q),
        .i_read_clear(ev_clear),
        .i_mask_we(ev_mask_we),
        .i_mask_wdata(i_avs_writedata[5:0]),
        .o_status(ev_status),
        .o_mask(ev_mask),
        .o_irq(o_irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic h_snan, h_widen_mul, h_fast_zero, h_addsub_masked, h_divzero, h_div_sign, h_ovf_masked;
    assign h_snan = i_op_valid & any_snan;
    assign h_widen_mul = i_op_valid & is_widen_mul & ~any_nan;
    assign h_fast_zero = i_op_valid & numeric & uf & ~i_intermediate_overflow & unf_mask & fast_float_enable;
    assign h_addsub_masked = i_op_valid & (is_add | is_sub) & unf_mask & ~fast_float_enable;
    assign h_divzero = i_op_valid & is_div & ~any_nan & za & ~zb & ~ia;
    assign h_div_sign = sx;
    assign h_ovf_masked = ovf_mask;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    chk_supp_keeps_dest: assert property (o_result_suppressed |-> $stable(o_result))
        else $error("destination changed on a suppressed result");
    chk_snan_status: assert property (h_snan |=> o_exc_status[ST_N] && o_exc_status[ST_R]
        && o_result_write) else $error("signalling nan status wrong");
    chk_widen_quiet: assert property (h_widen_mul |=> !o_exc_status[ST_V] && !o_exc_status[ST_U]
        && !o_exc_status[ST_X]) else $error("widening multiply raised an output exception");
    chk_fast_zero_sign: assert property (h_fast_zero |=> o_result_write && o_exc_status[ST_U]
        && o_result == fp_val($past(dbl_out), $past(i_intermediate_sign), 64'h0, 32'h0))
        else $error("fast-float underflow not a signed zero");
    chk_addsub_no_unf: assert property (h_addsub_masked |=> !o_exc_status[ST_U])
        else $error("masked add or subtract reported underflow");
    chk_div_zero_sign: assert property (h_divzero |=>
        o_result == fp_val($past(dbl_out), $past(h_div_sign), 64'h0, 32'h0)) else $error("divide zero sign wrong");
    chk_ovf_unmasked: assert property (o_res_valid && o_exc_status[ST_V] && !$past(h_ovf_masked)
        |-> !o_result_write && o_trap) else $error("unmasked overflow was written");
    chk_rank_single: assert property (o_res_valid && o_exc_status[ST_R] |-> !o_exc_status[ST_V]
        && !o_exc_status[ST_U] && !o_exc_status[ST_X] && !o_exc_status[ST_D]) else $error("two ranks");
    chk_sticky_masked: assert property (!$past(sticky_we) |-> ((sticky_q & ~$past(sticky_q))
        & ~$past(masks)) == 6'h0) else $error("sticky bit set while masked off");
endmodule

// ===== dv/fpx_regfile_model.sv
/*
 * fpx_regfile_model: the destination register of the core's register file.
 * assumes a write pulse arrives together with its result on one edge.
 */
`timescale 1ns/1ps
module fpx_regfile_model (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_write,
    input wire logic [63:0] i_data,
    output logic [63:0] o_dest
);
    logic [63:0] dest_q;
    logic [63:0] dest_d;

    always_comb begin
        dest_d = i_write ? i_data : dest_q;
    end

    always_ff @(posedge i_clock) begin
        dest_q <= !i_rstn ? 64'h0 : dest_d;
    end

    assign o_dest = dest_q;
endmodule

// ===== dv/tb_fp_exception_result_select.sv
/*
 * tb_fp_exception_result_select: random ops against a behavioural model.
 * assumes a one-cycle op latency and a two-cycle register bus access.
 */
`timescale 1ns/1ps
module tb_fp_exception_result_select;
    import fpx_pkg::*;
    logic clk, rstn, rd, wr, v, sg, ov, ty, ix, wreq, rv, wrt, sup, trap, irq;
    logic [7:0] addr;
    logic [31:0] wd, rdata, rs, d, r;
    logic [3:0] be;
    fpx_op_t opc;
    logic [63:0] a, b, rr, res, dest, rfd;
    logic [5:0] st, stk, ev, trp, evm;
    logic [8:0] ctl;
    logic [71:0] q[$];
    int err_total, checks_done;

    fpx_exc_select dut (.i_clock(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_op_valid(v), .i_op_code(opc), .i_first_source_operand(a), .i_second_source_operand(b),
        .i_rounded_result(rr), .i_intermediate_sign(sg), .i_intermediate_overflow(ov),
        .i_intermediate_tiny(ty), .i_intermediate_inexact(ix), .o_res_valid(rv), .o_result(res),
        .o_result_write(wrt), .o_result_suppressed(sup), .o_exc_status(st), .o_trap(trap), .o_irq(irq));
    fpx_regfile_model rf (.i_clock(clk), .i_rstn(rstn), .i_write(wrt), .i_data(res), .o_dest(rfd));

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // {sign, zero, inf, qnan, snan}
    function automatic logic [4:0] cls(input logic [63:0] x, input logic dp);
        logic e1;
        logic fz;
        logic qb;
        e1 = dp ? &x[62:52] : &x[30:23];
        fz = dp ? x[51:0] == 52'h0 : x[22:0] == 23'h0;
        qb = dp ? x[51] : x[22];
        cls = {dp ? x[63] : x[31], dp ? x[62:0] == 63'h0 : x[30:0] == 31'h0, e1 & fz, e1 & qb, e1 & !qb & !fz};
    endfunction

    function automatic logic [63:0] mk(input logic [3:0] k, input logic s, input logic dp);
        logic [63:0] m;
        case (k)
            4'h0: m = dp ? 64'h7ff0000000000001 : 64'h7f800001;
            4'h1: m = dp ? 64'h7ff8000000000000 : 64'h7fc00000;
            4'h2: m = dp ? INF_D : {32'h0, INF_S};
            4'h3: m = 64'h0;
            default: m = dp ? 64'h3ff8000000000000 : 64'h3fc00000;
        endcase
        mk = m | (s ? (dp ? 64'h8000000000000000 : 64'h80000000) : 64'h0);
    endfunction

    // f = {sign, overflow, tiny, inexact}; returns {write, status, result}
    function automatic logic [70:0] model(input fpx_op_t op, input logic [63:0] x, input logic [63:0] y,
            input logic [63:0] rres, input logic [8:0] c, input logic [3:0] f);
        logic di, dr, w;
        logic [4:0] ca, cb;
        logic [63:0] sb, inf, mx, qn, sx, rs2;
        logic [5:0] s;
        int k;
        di = op inside {double_add_op, double_subtract_op, double_multiply_op, double_divide_op};
        dr = di || op == single_to_double_multiply;
        k = op == single_to_double_multiply ? 2 : int'(op) / 2;
        ca = cls(x, di);
        cb = cls(y, di);
        sb = dr ? 64'h8000000000000000 : 64'h80000000;
        inf = dr ? INF_D : {32'h0, INF_S};
        mx = dr ? MAX_D : {32'h0, MAX_S};
        qn = dr ? QNAN_D : {32'h0, QNAN_S};
        sx = (ca[4] ^ cb[4]) ? sb : 64'h0;
        s = 6'h0;
        w = 1'b1;
        rs2 = rres;
        if (ca[0] | cb[0]) begin
            rs2 = qn;
            s = 6'h03;
        end else if (ca[1] | cb[1]) begin
            rs2 = qn;
            s = 6'h02;
        end else if (ca[2] | cb[2] | (k > 1 & (ca[3] | cb[3]))) begin
            case (k)
                0, 1: begin
                    s = (ca[2] & cb[2] & (ca[4] ^ cb[4] ^ k[0])) ? 6'h03 : 6'h0;
                    rs2 = inf | ((ca[2] ? ca[4] : cb[4] ^ k[0]) ? sb : 64'h0);
                end
                2: begin
                    s = ((ca[2] & cb[3]) | (ca[3] & cb[2])) ? 6'h03 : 6'h0;
                    rs2 = (ca[2] | cb[2]) ? inf | sx : sx;
                end
                default: begin
                    s = ((ca[2] & cb[2]) | (ca[3] & cb[3])) ? 6'h03 : (cb[3] & !ca[2]) ? 6'h20 : 6'h0;
                    rs2 = (ca[2] | cb[3]) ? inf | sx : sx;
                end
            endcase
            if (s[0]) rs2 = qn;
        end else if (op == single_to_double_multiply) begin
            s = 6'h0;
        end else if (f[2]) begin
            s = 6'h14;
            if (c[ST_V]) rs2 = ((c[8:7] == 2'h0 || c[8:7] == (f[3] ? 2'h1 : 2'h2)) ? inf : mx) | (f[3] ? sb : 64'h0);
            else begin
                w = 1'b0;
                s = {1'b0, f[0], 4'h4};
            end
        end else if (f[1] && (!c[ST_U] || c[CTL_FAST] || (f[0] && k > 1))) begin
            s = 6'h18;
            if (!c[ST_U]) begin
                w = 1'b0;
                s = {1'b0, f[0], 4'h8};
            end else if (c[CTL_FAST]) rs2 = f[3] ? sb : 64'h0;
        end else if (f[0]) begin
            s = 6'h10;
            w = c[ST_X];
        end
        model = {w, s, rs2};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    function automatic logic [31:0] rnd();
        repeat (16) rs = rs[0] ? (rs >> 1) ^ 32'h80200003 : rs >> 1;
        return rs;
    endfunction

    task bus(input logic w, input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] bs, output logic [31:0] o);
        int n;
        logic wq;
        @(posedge clk);
        addr <= ad;
        wd <= dt;
        be <= bs;
        if (w) wr <= 1'b1;
        else rd <= 1'b1;
        n = 0;
        wq = 1'b1;
        while (wq) begin
            @(posedge clk);
            wq = wreq;
            o = rdata;
            n++;
            if (wq && n > 20) begin
                err_total++;
                end_sim;
            end
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task gen;
        logic [31:0] r1, r2;
        logic dd;
        logic [63:0] x, y, rrv;
        logic [3:0] f;
        logic [70:0] m;
        fpx_op_t o;
        r1 = rnd();
        r2 = rnd();
        o = fpx_op_t'(4'(r1 % 9));
        dd = o inside {double_add_op, double_subtract_op, double_multiply_op, double_divide_op};
        x = mk(r1[7:4], r1[8], dd);
        y = mk(r1[12:9], r1[13], dd);
        f = (r1[7:4] > 4'h3 && r1[12:9] > 4'h3) ? {r1[14], r1[16:15] == 2'h1, r1[16:15] == 2'h2, r1[17]} : 4'h0;
        rrv = (dd || o == single_to_double_multiply) ? {r2, r1} : {32'h0, r2};
        m = model(o, x, y, rrv, ctl, f);
        q.push_back({|(m[69:64] & ~ctl[5:0]), m});
        opc <= o;
        a <= x;
        b <= y;
        rr <= rrv;
        {sg, ov, ty, ix} <= f;
        v <= 1'b1;
    endtask

    task chk_op;
        logic [71:0] x;
        x = q.pop_front();
        chk("dest", dest, rfd);
        if (x[70]) dest = x[63:0];
        chk("valid", 64'(1), 64'(rv));
        chk("write", 64'(x[70]), 64'(wrt));
        chk("suppressed", 64'(!x[70]), 64'(sup));
        chk("status", 64'(x[69:64]), 64'(st));
        chk("trap", 64'(x[71]), 64'(trap));
        chk("result", dest, res);
        stk = stk | (x[69:64] & ctl[5:0]);
        if (x[71]) begin
            ev = ev | x[69:64];
            trp = x[69:64];
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        {rstn, rd, wr, v, sg, ov, ty, ix} = 8'h0;
        {addr, wd, be, a, b, rr} = '0;
        opc = single_add_op;
        rs = 32'h62d4;
        {err_total, checks_done} = '0;
        {dest, stk, ev, trp} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, OFS_CONTROL, 32'h0, 4'h3, d);
        chk("control reset", 64'h3f, 64'(d));
        bus(1'b1, 8'h20, 32'hffffffff, 4'hf, d);
        bus(1'b0, 8'h20, 32'h0, 4'hf, d);
        chk("unmapped", 64'h0, 64'(d));
        for (int blk = 0; blk < 40; blk++) begin
            r = rnd();
            ctl = blk == 0 ? 9'h03f : r[8:0];
            evm = r[14:9];
            bus(1'b1, OFS_CONTROL, {23'h0, ctl}, 4'h3, d);
            bus(1'b1, OFS_EVMASK, {26'h0, evm}, 4'h1, d);
            for (int i = 0; i <= 16; i++) begin
                @(posedge clk);
                if (i < 16) gen;
                else v <= 1'b0;
                #1;
                if (i > 0) chk_op;
            end
            repeat (3) @(posedge clk);
            #1;
            chk("irq", 64'(|(ev & evm)), 64'(irq));
            bus(1'b0, OFS_STICKY, 32'h0, 4'h1, d);
            chk("sticky", 64'(stk), 64'(d));
            bus(1'b1, OFS_STICKY, 32'h0, 4'h1, d);
            stk = 6'h0;
            bus(1'b0, OFS_TRAP, 32'h0, 4'h1, d);
            chk("trap reg", 64'(trp), 64'(d));
            bus(1'b0, OFS_EVENT, 32'h0, 4'h1, d);
            chk("event", 64'(ev), 64'(d));
            ev = 6'h0;
            repeat (2) @(posedge clk);
            #1;
            chk("irq clear", 64'h0, 64'(irq));
        end
        end_sim;
    end
endmodule
